// file: logic/mcrc_defs.vh
// Constants for the motor current regulation block
`ifndef MCRC_DEFS_VH
`define MCRC_DEFS_VH
// Decoded current-mode levels of the four-level select input
`define MCRC_LVL_GND      2'h0
`define MCRC_LVL_PD_LOW   2'h1
`define MCRC_LVL_PD_HIGH  2'h2
`define MCRC_LVL_OPEN     2'h3
// Bridge control modes
`define MCRC_BR_PHEN      2'h0
`define MCRC_BR_PWM       2'h1
`define MCRC_BR_HALF      2'h2
// Timing in ns, clock period in ns
`define MCRC_CLK_NS       25
`define MCRC_DBLANK_NS    2000
`define MCRC_ABLANK_NS    1000
`define MCRC_TOFF_NS      20000
`define MCRC_RETRY_NS     100000
// Interval lengths in cycles of the nominal clock
`define MCRC_DBLANK_CYC   16'h0050
`define MCRC_ABLANK_CYC   16'h0028
`define MCRC_TOFF_CYC     16'h0320
`define MCRC_RETRY_CYC    16'h0fa0
// Timer width
`define MCRC_TW           16
`endif

// file: logic/mcrc_timer.v
// One-shot down counter used for each independent interval
`timescale 1ns/10ps
`include "mcrc_defs.vh"
module mcrc_timer #(
	parameter [`MCRC_TW-1:0] COUNT = 16'h0001
) (
	// Clock and reset
	input  wire core_clk_in,
	input  wire sys_rst_in,
	// Control
	input  wire start_in,
	input  wire stop_in,
	// Status
	output wire busy_out,
	output wire done_out
);
	reg [`MCRC_TW-1:0] cnt_reg;

	assign busy_out = (cnt_reg != {`MCRC_TW{1'b0}});
	assign done_out = (cnt_reg == {{(`MCRC_TW-1){1'b0}}, 1'b1});

	always @(posedge core_clk_in)
	begin
		if (sys_rst_in || stop_in)
			cnt_reg <= {`MCRC_TW{1'b0}};
		else if (start_in)
			cnt_reg <= COUNT;
		else if (busy_out)
			cnt_reg <= cnt_reg - {{(`MCRC_TW-1){1'b0}}, 1'b1};
	end
endmodule // mcrc_timer

// file: logic/mcrc_core.v
// Current regulation and overcurrent control of an H-bridge driver
// Contract
// R01 - Latch current mode at wake, hold
// R02 - Host sleeps, settles, changes mode, wakes
// R03 - Ground/open fixed off-time, pull-downs edge brake
// R04 - Ground/low pull-down retry, others latch
// R05 - Edge modes flag threshold events too
// R06 - Overcurrent turns bridge switches off
// R07 - Threshold exceedance starts selected regulation
// R08 - Comparator passes digital and analog blanking
// R09 - Digital at cycle start, analog at threshold
// R10 - Edge mode restarts digital blank on edges
// R11 - Digital blank masks positive current only
// R12 - Both blanking timers fully independent
// R13 - Fixed mode short brakes one off-time
// R14 - After off-time follow inputs or rebrake
// R15 - Edge mode brakes until next input edge
// R16 - Only new input edge ends edge brake; here wake going low also clears it
// R17 - Flag low on exceedance until edge
// R18 - Half-bridge mode disables regulation only
// R19 - Decode mode into two-bit latched code
`timescale 1ns/10ps
`include "mcrc_defs.vh"
module mcrc_core #(
	parameter [`MCRC_TW-1:0] DBLANK_CYC = `MCRC_DBLANK_CYC,
	parameter [`MCRC_TW-1:0] ABLANK_CYC = `MCRC_ABLANK_CYC,
	parameter [`MCRC_TW-1:0] TOFF_CYC   = `MCRC_TOFF_CYC,
	parameter [`MCRC_TW-1:0] RETRY_CYC  = `MCRC_RETRY_CYC
) (
	// Clock and reset
	input  wire       core_clk_in,
	input  wire       sys_rst_in,
	// Host pins
	input  wire       wake_control_in,
	input  wire [1:0] current_mode_select_in,
	input  wire [1:0] bridge_mode_select_in,
	input  wire       bridge_input_a_in,
	input  wire       bridge_input_b_in,
	// Analog side
	input  wire       current_threshold_in,
	input  wire       current_positive_in,
	input  wire       overcurrent_shutdown_in,
	// Bridge switches
	output reg        high_side_1_out,
	output reg        low_side_1_out,
	output reg        high_side_2_out,
	output reg        low_side_2_out,
	// Status
	output reg        fault_flag_low_out,
	output reg  [1:0] mode_code_out
);
	// Pin synchronisers: three stages, change when stages two and three agree
	reg [2:0] wk_s, a_s, b_s, th_s, pos_s, oc_s;
	reg wk_reg, a_reg, b_reg, th_reg, pos_reg, oc_reg;
	reg [1:0] cm_s0, cm_s1, cm_s2, bm_s0, bm_s1, bm_s2;
	always @(posedge core_clk_in)
	begin
		if (sys_rst_in)
		begin
			wk_s <= 3'h0; a_s <= 3'h0; b_s <= 3'h0;
			th_s <= 3'h0; pos_s <= 3'h0; oc_s <= 3'h0;
			wk_reg <= 1'b0; a_reg <= 1'b0; b_reg <= 1'b0;
			th_reg <= 1'b0; pos_reg <= 1'b0; oc_reg <= 1'b0;
			cm_s0 <= 2'h0; cm_s1 <= 2'h0; cm_s2 <= 2'h0;
			bm_s0 <= 2'h0; bm_s1 <= 2'h0; bm_s2 <= 2'h0;
		end
		else
		begin
			wk_s <= {wk_s[1:0], wake_control_in};
			a_s <= {a_s[1:0], bridge_input_a_in};
			b_s <= {b_s[1:0], bridge_input_b_in};
			th_s <= {th_s[1:0], current_threshold_in};
			pos_s <= {pos_s[1:0], current_positive_in};
			oc_s <= {oc_s[1:0], overcurrent_shutdown_in};
			cm_s0 <= current_mode_select_in;
			cm_s1 <= cm_s0;
			cm_s2 <= cm_s1;
			bm_s0 <= bridge_mode_select_in;
			bm_s1 <= bm_s0;
			bm_s2 <= bm_s1;
			if (wk_s[1] == wk_s[2]) wk_reg <= wk_s[2];
			if (a_s[1] == a_s[2]) a_reg <= a_s[2];
			if (b_s[1] == b_s[2]) b_reg <= b_s[2];
			if (th_s[1] == th_s[2]) th_reg <= th_s[2];
			if (pos_s[1] == pos_s[2]) pos_reg <= pos_s[2];
			if (oc_s[1] == oc_s[2]) oc_reg <= oc_s[2];
		end
	end

	// Mode latched at wake
	reg       wk_d;
	reg [1:0] cm_lat_reg, bm_lat_reg;
	reg       a_d, b_d;
	wire      wake_rise = wk_reg & ~wk_d;
	wire      edge_in = (a_reg ^ a_d) | (b_reg ^ b_d);
	wire      edge_mode = (cm_lat_reg == `MCRC_LVL_PD_LOW) ||
		(cm_lat_reg == `MCRC_LVL_PD_HIGH);                    // [R03]
	wire      auto_retry = (cm_lat_reg == `MCRC_LVL_GND) ||
		(cm_lat_reg == `MCRC_LVL_PD_LOW);                     // [R04]
	wire      reg_en = wk_reg && (bm_lat_reg != `MCRC_BR_HALF); // [R18]

	always @(posedge core_clk_in)
	begin
		if (sys_rst_in)
		begin
			wk_d <= 1'b0; a_d <= 1'b0; b_d <= 1'b0;
			cm_lat_reg <= `MCRC_LVL_GND;
			bm_lat_reg <= `MCRC_BR_PHEN;
		end
		else
		begin
			wk_d <= wk_reg;
			a_d <= a_reg;
			b_d <= b_reg;
			if (wake_rise && (cm_s1 == cm_s2))
			begin
				cm_lat_reg <= cm_s2;                          // [R01] [R19]
				bm_lat_reg <= bm_s2;
			end
		end
	end

	// Requested bridge state from the inputs
	reg hs1_r, ls1_r, hs2_r, ls2_r;
	always @*
	begin
		hs1_r = 1'b0; ls1_r = 1'b0; hs2_r = 1'b0; ls2_r = 1'b0;
		case (bm_lat_reg)
			`MCRC_BR_PHEN:
			begin
				hs1_r = a_reg & b_reg;  ls1_r = ~(a_reg & b_reg);
				hs2_r = a_reg & ~b_reg; ls2_r = ~(a_reg & ~b_reg);
			end
			`MCRC_BR_PWM:
			begin
				hs1_r = a_reg & ~b_reg; ls1_r = b_reg;
				hs2_r = b_reg & ~a_reg; ls2_r = a_reg;
			end
			default:
			begin
				hs1_r = a_reg; ls1_r = ~a_reg;
				hs2_r = b_reg; ls2_r = ~b_reg;
			end
		endcase
	end
	wire driving = hs1_r ^ hs2_r;

	// Blanking timers, each independent
	wire cycle_start = wake_rise || (edge_mode && edge_in);   // [R09] [R10]
	wire db_busy, ab_done, ab_busy, toff_done, toff_busy, rt_done, rt_busy;
	mcrc_timer #(.COUNT(DBLANK_CYC)) u_dblank (              // [R12]
		.core_clk_in (core_clk_in),
		.sys_rst_in  (sys_rst_in),
		.start_in    (cycle_start),
		.stop_in     (1'b0),
		.busy_out    (db_busy),
		.done_out    ()
	);
	reg th_d;
	wire ab_start = th_reg & ~th_d;                            // [R09]
	mcrc_timer #(.COUNT(ABLANK_CYC)) u_ablank (              // [R12]
		.core_clk_in (core_clk_in),
		.sys_rst_in  (sys_rst_in),
		.start_in    (ab_start),
		.stop_in     (~th_reg),
		.busy_out    (ab_busy),
		.done_out    (ab_done)
	);
	wire db_mask = db_busy & pos_reg;                          // [R11]
	// Analog window stays passed while the comparator stays high
	wire ab_passed = ab_done | (th_d & ~ab_busy);              // [R08]
	wire detect = ab_passed & th_reg & ~db_mask & driving & reg_en; // [R07]

	// Regulation state
	reg brake_reg, tfire;
	wire toff_start = tfire;
	mcrc_timer #(.COUNT(TOFF_CYC)) u_toff (
		.core_clk_in (core_clk_in),
		.sys_rst_in  (sys_rst_in),
		.start_in    (toff_start),
		.stop_in     (~wk_reg),
		.busy_out    (toff_busy),
		.done_out    (toff_done)
	);

	// Overcurrent handling
	reg oc_lat_reg, oc_d;
	wire oc_rise = oc_reg & ~oc_d;
	mcrc_timer #(.COUNT(RETRY_CYC)) u_retry (
		.core_clk_in (core_clk_in),
		.sys_rst_in  (sys_rst_in),
		.start_in    (oc_rise & auto_retry & wk_reg),
		.stop_in     (~wk_reg),
		.busy_out    (rt_busy),
		.done_out    (rt_done)
	);
	wire oc_off = oc_lat_reg | rt_busy | oc_reg;

	always @(posedge core_clk_in)
	begin
		if (sys_rst_in)
		begin
			th_d <= 1'b0; oc_d <= 1'b0;
			brake_reg <= 1'b0; tfire <= 1'b0; oc_lat_reg <= 1'b0;
		end
		else
		begin
			th_d <= th_reg;
			oc_d <= oc_reg;
			tfire <= 1'b0;
			if (!wk_reg || !reg_en)
				brake_reg <= 1'b0;
			else if (edge_mode)
			begin
				if (edge_in)
					brake_reg <= 1'b0;                        // [R16]
				else if (detect)
					brake_reg <= 1'b1;                        // [R15] [R07]
			end
			else
			begin
				if (toff_done && th_reg)
					tfire <= 1'b1;                            // [R14]
				else if (toff_done)
					brake_reg <= 1'b0;                        // [R14]
				else if (detect && !toff_busy && !brake_reg)
				begin
					brake_reg <= 1'b1;                        // [R13]
					tfire <= 1'b1;
				end
			end
			if (!wk_reg)
				oc_lat_reg <= 1'b0;
			else if (oc_rise && !auto_retry)
				oc_lat_reg <= 1'b1;                           // [R04]
		end
	end

	// Registered outputs
	always @(posedge core_clk_in)
	begin
		if (sys_rst_in)
		begin
			high_side_1_out <= 1'b0; low_side_1_out <= 1'b0;
			high_side_2_out <= 1'b0; low_side_2_out <= 1'b0;
			fault_flag_low_out <= 1'b1;
			mode_code_out <= `MCRC_LVL_GND;
		end
		else
		begin
			mode_code_out <= cm_lat_reg;                      // [R19]
			if (!wk_reg || oc_off)
			begin
				high_side_1_out <= 1'b0; low_side_1_out <= 1'b0; // [R06]
				high_side_2_out <= 1'b0; low_side_2_out <= 1'b0;
			end
			else if (brake_reg)
			begin
				high_side_1_out <= 1'b0; low_side_1_out <= 1'b1; // [R13] [R15]
				high_side_2_out <= 1'b0; low_side_2_out <= 1'b1;
			end
			else
			begin
				high_side_1_out <= hs1_r; low_side_1_out <= ls1_r;
				high_side_2_out <= hs2_r; low_side_2_out <= ls2_r;
			end
			fault_flag_low_out <= ~((wk_reg && oc_off) ||
				(edge_mode && brake_reg));                    // [R05] [R17]
		end
	end
endmodule // mcrc_core

// file: tb/mcrc_checker.sv
// Port-level assertions for the current regulation core
`timescale 1ns/10ps
`include "mcrc_defs.vh"
module mcrc_checker (
	input wire       core_clk_in,
	input wire       sys_rst_in,
	input wire       wake_control_in,
	input wire [1:0] current_mode_select_in,
	input wire       bridge_input_a_in,
	input wire       bridge_input_b_in,
	input wire       overcurrent_shutdown_in,
	input wire       high_side_1_out,
	input wire       low_side_1_out,
	input wire       high_side_2_out,
	input wire       low_side_2_out,
	input wire       fault_flag_low_out,
	input wire [1:0] mode_code_out
);
	reg       wake_q_reg;
	reg       a_q_reg;
	reg       b_q_reg;
	reg [1:0] lat_reg;
	reg [3:0] quiet_reg;
	wire      brk = low_side_1_out && low_side_2_out;
	wire      any_sw = high_side_1_out || low_side_1_out || high_side_2_out
		|| low_side_2_out;
	// Own copy of the mode taken at wake, cycles since the last input edge
	always @(posedge core_clk_in)
	begin
		wake_q_reg <= wake_control_in;
		a_q_reg <= bridge_input_a_in;
		b_q_reg <= bridge_input_b_in;
		if (wake_control_in && !wake_q_reg)
			lat_reg <= current_mode_select_in;
		if (sys_rst_in || bridge_input_a_in != a_q_reg
			|| bridge_input_b_in != b_q_reg)
			quiet_reg <= 4'h0;
		else if (quiet_reg != 4'hf)
			quiet_reg <= quiet_reg + 4'h1;
	end
	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (sys_rst_in);
	mode_hold_a: assert property (wake_control_in [*8] |=>
		$stable(mode_code_out)) else $error("mode code moved while awake");
	ocp_off_a: assert property (overcurrent_shutdown_in [*6] |->
		!any_sw) else $error("switches on during overcurrent");
	ocp_fault_a: assert property ((overcurrent_shutdown_in
		&& wake_control_in) [*6] |-> !fault_flag_low_out)
		else $error("no fault on overcurrent");
	ocp_latch_a: assert property (($fell(overcurrent_shutdown_in)
		&& lat_reg == `MCRC_LVL_PD_HIGH) ##1 wake_control_in [*8] |-> !any_sw)
		else $error("latched shutdown released");
	fixed_toff_a: assert property ($rose(brk) && bridge_input_a_in
		&& lat_reg == `MCRC_LVL_GND && wake_control_in |-> brk [*8])
		else $error("off-time brake too short");
	edge_hold_a: assert property (lat_reg == `MCRC_LVL_PD_LOW && brk
		&& quiet_reg > 4'h6 && wake_control_in |=> brk)
		else $error("edge brake ended without edge");
	edge_fault_a: assert property (lat_reg == `MCRC_LVL_PD_LOW && brk
		&& quiet_reg > 4'h6 && bridge_input_a_in |-> !fault_flag_low_out)
		else $error("no fault during edge brake");
	edge_release_a: assert property (lat_reg == `MCRC_LVL_PD_LOW
		&& brk && quiet_reg == 4'h0 && bridge_input_a_in && wake_control_in
		|-> ##[1:8] !brk) else $error("edge did not end brake");
	cover property ($rose(brk));
	cover property ($fell(fault_flag_low_out));
	cover property ($rose(overcurrent_shutdown_in));
endmodule // mcrc_checker
bind mcrc_core mcrc_checker mcrc_checker_inst (
	.core_clk_in             (core_clk_in),
	.sys_rst_in              (sys_rst_in),
	.wake_control_in         (wake_control_in),
	.current_mode_select_in  (current_mode_select_in),
	.bridge_input_a_in       (bridge_input_a_in),
	.bridge_input_b_in       (bridge_input_b_in),
	.overcurrent_shutdown_in (overcurrent_shutdown_in),
	.high_side_1_out         (high_side_1_out),
	.low_side_1_out          (low_side_1_out),
	.high_side_2_out         (high_side_2_out),
	.low_side_2_out          (low_side_2_out),
	.fault_flag_low_out      (fault_flag_low_out),
	.mode_code_out           (mode_code_out)
);

// file: tb/mcrc_host_model.sv
// Host model driving the bridge and mode pins
`timescale 1ns/10ps
module mcrc_host_model (
	input  wire       core_clk_in,
	output reg        wake_control_in,
	output reg  [1:0] current_mode_select_in,
	output reg  [1:0] bridge_mode_select_in,
	output reg        bridge_input_a_in,
	output reg        bridge_input_b_in
);
	initial
	begin
		wake_control_in = 1'b0;
		current_mode_select_in = 2'h0;
		bridge_mode_select_in = 2'h0;
		bridge_input_a_in = 1'b0;
		bridge_input_b_in = 1'b0;
	end
	task step(input integer n);
	begin
		repeat (n) @(posedge core_clk_in);
		#1;
	end
	endtask
	// Sleep, settle, apply the new mode, wake
	task rewake(input [1:0] mode);
	begin
		step(1);
		wake_control_in = 1'b0;
		step(8);
		current_mode_select_in = mode;
		step(4);
		wake_control_in = 1'b1;
		step(12);
	end
	endtask
	// A new control edge, which also ends an edge brake
	task drive(input a, input b);
	begin
		step(1);
		bridge_input_a_in = a;
		bridge_input_b_in = b;
	end
	endtask
endmodule // mcrc_host_model

// file: tb/mcrc_core_bench.sv
// Self-checking bench for the current regulation core
`timescale 1ns/10ps
`include "mcrc_defs.vh"
`define CHK(got, exp) \
	begin n_compared = n_compared + 1; if ((got) !== (exp)) begin \
	error_cnt = error_cnt + 1; \
	$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp); end end
module mcrc_core_bench;
	reg        core_clk_in, sys_rst_in, current_threshold_in;
	reg        current_positive_in, overcurrent_shutdown_in;
	wire       wake_control_in, bridge_input_a_in, bridge_input_b_in;
	wire [1:0] current_mode_select_in, bridge_mode_select_in, mode_code_out;
	wire       high_side_1_out, low_side_1_out, high_side_2_out;
	wire       low_side_2_out, fault_flag_low_out;
	wire [3:0] sw = {high_side_1_out, low_side_1_out, high_side_2_out,
		low_side_2_out};
	integer    error_cnt, n_compared, i;
	mcrc_core #(.DBLANK_CYC(16'h0004), .ABLANK_CYC(16'h0003),
		.TOFF_CYC(16'h000a), .RETRY_CYC(16'h0014)) mcrc_core_inst (
		.core_clk_in             (core_clk_in),
		.sys_rst_in              (sys_rst_in),
		.wake_control_in         (wake_control_in),
		.current_mode_select_in  (current_mode_select_in),
		.bridge_mode_select_in   (bridge_mode_select_in),
		.bridge_input_a_in       (bridge_input_a_in),
		.bridge_input_b_in       (bridge_input_b_in),
		.current_threshold_in    (current_threshold_in),
		.current_positive_in     (current_positive_in),
		.overcurrent_shutdown_in (overcurrent_shutdown_in),
		.high_side_1_out         (high_side_1_out),
		.low_side_1_out          (low_side_1_out),
		.high_side_2_out         (high_side_2_out),
		.low_side_2_out          (low_side_2_out),
		.fault_flag_low_out      (fault_flag_low_out),
		.mode_code_out           (mode_code_out)
	);
	mcrc_host_model mcrc_host_model_inst (
		.core_clk_in            (core_clk_in),
		.wake_control_in        (wake_control_in),
		.current_mode_select_in (current_mode_select_in),
		.bridge_mode_select_in  (bridge_mode_select_in),
		.bridge_input_a_in      (bridge_input_a_in),
		.bridge_input_b_in      (bridge_input_b_in)
	);
	task wt(input integer n);
	begin
		mcrc_host_model_inst.step(n);
	end
	endtask
	task wait_sw(input [3:0] v);
	begin
		for (i = 0; i < 30 && sw !== v; i = i + 1)
			wt(1);
	end
	endtask
	task results;
	begin
		$display("compared %0d errors %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	end
	endtask
	// Fixed off-time, mode changed while awake is ignored
	task t_fixed;
	begin
		mcrc_host_model_inst.rewake(`MCRC_LVL_GND);
		mcrc_host_model_inst.drive(1'b1, 1'b1);
		mcrc_host_model_inst.current_mode_select_in = `MCRC_LVL_PD_LOW;
		current_threshold_in = 1'b1;
		wt(2);
		current_threshold_in = 1'b0;
		wt(12);
		`CHK(sw, 4'h9)
		current_threshold_in = 1'b1;
		wait_sw(4'h5);
		`CHK(sw, 4'h5)
		`CHK(fault_flag_low_out, 1'b1)
		wt(14);
		`CHK(sw, 4'h5)
		current_threshold_in = 1'b0;
		wt(30);
		`CHK(sw, 4'h9)
		`CHK(fault_flag_low_out, 1'b1)
		`CHK(mode_code_out, `MCRC_LVL_GND)
	end
	endtask
	// Edge-terminated brake and its fault report
	task t_edge;
	begin
		mcrc_host_model_inst.rewake(`MCRC_LVL_PD_LOW);
		current_threshold_in = 1'b1;
		wait_sw(4'h5);
		`CHK(fault_flag_low_out, 1'b0)
		`CHK(mode_code_out, `MCRC_LVL_PD_LOW)
		current_threshold_in = 1'b0;
		wt(30);
		`CHK(sw, 4'h5)
		mcrc_host_model_inst.drive(1'b1, 1'b0);
		wt(8);
		`CHK(sw, 4'h6)
		`CHK(fault_flag_low_out, 1'b1)
	end
	endtask
	// Digital blank masks charge current only and restarts on edges
	task t_blank;
	begin
		current_positive_in = 1'b0;
		mcrc_host_model_inst.drive(1'b1, 1'b1);
		current_threshold_in = 1'b1;
		wt(9);
		`CHK(sw, 4'h5)
		current_positive_in = 1'b1;
		mcrc_host_model_inst.drive(1'b1, 1'b0);
		wt(9);
		`CHK(sw, 4'h6)
		wt(3);
		`CHK(sw, 4'h5)
		current_threshold_in = 1'b0;
		mcrc_host_model_inst.drive(1'b1, 1'b1);
		wt(8);
		`CHK(sw, 4'h9)
		`CHK(fault_flag_low_out, 1'b1)
	end
	endtask
	// Overcurrent, latched then auto-retry
	task t_ocp(input [1:0] mode, input [3:0] exp);
	begin
		mcrc_host_model_inst.rewake(mode);
		overcurrent_shutdown_in = 1'b1;
		wt(6);
		`CHK(sw, 4'h0)
		`CHK(fault_flag_low_out, 1'b0)
		overcurrent_shutdown_in = 1'b0;
		wt(40);
		`CHK(sw, exp)
		`CHK(fault_flag_low_out, |exp)
	end
	endtask
	// Half bridges ignore the threshold
	task t_half;
	begin
		mcrc_host_model_inst.bridge_mode_select_in = `MCRC_BR_HALF;
		mcrc_host_model_inst.rewake(`MCRC_LVL_GND);
		current_threshold_in = 1'b1;
		wt(20);
		`CHK(sw, 4'h9)
	end
	endtask
	initial
	begin
		core_clk_in = 1'b0;
		forever #12.5 core_clk_in = ~core_clk_in;
	end
	initial
	begin
		#250000;
		error_cnt = error_cnt + 1;
		results;
	end
	initial
	begin
		error_cnt = 0;
		n_compared = 0;
		sys_rst_in = 1'b1;
		current_threshold_in = 1'b0;
		current_positive_in = 1'b1;
		overcurrent_shutdown_in = 1'b0;
		wt(8);
		sys_rst_in = 1'b0;
		t_fixed;
		t_edge;
		t_blank;
		mcrc_host_model_inst.drive(1'b1, 1'b1);
		t_ocp(`MCRC_LVL_PD_HIGH, 4'h0);
		t_ocp(`MCRC_LVL_GND, 4'h9);
		mcrc_host_model_inst.drive(1'b1, 1'b0);
		t_half;
		results;
	end
endmodule // mcrc_core_bench
